// file: common/gpec_pkg.sv
// register map, field layout, reset values and carrier types of the six-pin port
// assumes a 32-bit apb slave with one aligned word per register
package gpec_pkg;

    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int NUM_PINS = 6;
    localparam int IN_ONLY_PIN = 3;
    localparam int PIN_AMP = 2;
    localparam int PIN_FOUR = 4;
    localparam int PIN_FIVE = 5;
    localparam int SEL_W = 3;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PIN_DATA = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h08;
    localparam logic [7:0] OFF_ANALOG_SELECT = 8'h0c;
    localparam logic [7:0] OFF_RISING_EDGE_ENABLE = 8'h10;
    localparam logic [7:0] OFF_FALLING_EDGE_ENABLE = 8'h14;
    localparam logic [7:0] OFF_CHANGE_FLAGS = 8'h18;
    localparam logic [7:0] OFF_PORT_CONFIG = 8'h1c;

    // port_config fields
    localparam int CFG_MCLR_BIT = 0;
    localparam int CFG_PEND_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_DIRECTION = 6'h3f;
    localparam logic [5:0] RST_ANALOG = 6'h3f;
    localparam logic [5:0] RST_LATCH = 6'h00;
    localparam logic [5:0] RST_EDGE_EN = 6'h00;
    localparam logic [5:0] RST_FLAGS = 6'h00;
    localparam logic RST_MCLR = 1'b0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // digital peripheral outputs that may take over a pin
    typedef struct packed {
        logic comp_one_en;
        logic comp_one;
        logic comp_zero_en;
        logic comp_zero;
        logic cmp_two_en;
        logic cmp_two;
        logic ccp_en;
        logic ccp;
        logic amp_en;
        logic amp;
    } gpec_periph_t;

    // one analog input function: peripheral enable and its pin selector
    typedef struct packed {
        logic en;
        logic [SEL_W-1:0] sel;
    } gpec_afn_t;

endpackage

// file: logic/gpec_port.sv
// six-pin port with direction, output latch, analog gating, edge change flags
// and fixed-priority peripheral output muxing; apb slave, zero wait states
// assumes pad inputs are asynchronous; peripheral and analog controls are on clk_i
//
// Functional notes
// - rising-edge enable set: detect low-to-high; clear: ignore rising edges
// - falling-edge enable set: detect high-to-low; clear: ignore falling edges
// - enabled edge sets the pin's change flag and the pending flag
// - flags read zero until an enabled edge; writing zero clears them
// - bits 7-6 of edge enable and flag registers read zero
// - direction bit one makes the pin an input, driver off
// - direction bit zero enables the driver with the latch value
// - input-only pin has no driver; its direction bit reads one
// - data read returns pin levels; data write goes to the latch
// - unstrobed data write is read-modify-write of sampled pins into the latch
// - master-clear selection makes the input-only pin read zero
// - direction still controls drivers on analog-selected pins
// - analog-selected pin reads zero in digital data reads
// - analog-selected pin never sets its change flag
// - analog selection blocks the digital input path
// - highest-priority enabled output function owns the pin
// - output functions still drive analog-selected pins, same priority
// - analog function active when enabled and selector points at pin
// - analog select bits reset to analog mode
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps

module gpec_port #(
    parameter int NUM_AFN = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pins
    input wire logic [gpec_pkg::NUM_PINS-1:0] pad_i,
    output logic [gpec_pkg::NUM_PINS-1:0] pad_o,
    output logic [gpec_pkg::NUM_PINS-1:0] pad_oe_o,
    // on-chip peripherals
    input wire gpec_pkg::gpec_periph_t periph_i,
    input wire gpec_pkg::gpec_afn_t [NUM_AFN-1:0] afn_i,
    output logic [gpec_pkg::NUM_PINS-1:0] ana_conn_o,
    output logic [gpec_pkg::NUM_PINS-1:0] dig_in_o,
    output logic change_pending_o
);

    localparam int N = gpec_pkg::NUM_PINS;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (NUM_AFN < 1 || NUM_AFN > 16) begin : g_bad_afn
        $error("gpec_port: NUM_AFN must be 1..16");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // one-hot pin decode of an analog selector; out-of-range selects nothing
    function automatic logic [N-1:0] pin_decode(input logic [gpec_pkg::SEL_W-1:0] sel);
        logic [N-1:0] hot;
        hot = '0;
        for (int p = 0; p < N; p++) begin
            if (sel == gpec_pkg::SEL_W'(p)) begin
                hot[p] = 1'b1;
            end
        end
        return hot;
    endfunction

    // place a six-bit field into a bus word, upper bits zero
    function automatic logic [31:0] word6(input logic [N-1:0] v);
        return {26'h0, v};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [N-1:0] latch_q;
    logic [N-1:0] dir_q;
    logic [N-1:0] ansel_q;
    logic [N-1:0] rise_en_q;
    logic [N-1:0] fall_en_q;
    logic [N-1:0] flags_q;
    logic mclr_sel_q;

    // ------------------------------------------------------------
    // pad input synchroniser and filter
    // ------------------------------------------------------------
    logic [N-1:0] sync1_q;
    logic [N-1:0] sync2_q;
    logic [N-1:0] sync3_q;
    logic [N-1:0] level_q;
    logic [N-1:0] dig_in;
    logic [N-1:0] dig_prev_q;
    logic [N-1:0] ansel_prev_q;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pad_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // a level change is accepted only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            level_q <= '0;
        end else begin
            for (int p = 0; p < N; p++) begin
                if (sync2_q[p] == sync3_q[p]) begin
                    level_q[p] <= sync3_q[p];
                end
            end
        end
    end

    // digital path blocked
    // analog pins present a constant low to all digital consumers
    assign dig_in = level_q & ~ansel_q;
    assign dig_in_o = dig_in;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup;
    logic wr_acc;
    logic addr_ok;
    logic err_q;
    logic [31:0] rdata_q;
    logic [N-1:0] pin_read;
    logic [N-1:0] wbyte;

    assign setup = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign wbyte = pwdata_i[N-1:0];

    always_comb begin
        if (paddr_i == gpec_pkg::OFF_PIN_DATA) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_OUTPUT_LATCH) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_PIN_DIRECTION) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_ANALOG_SELECT) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_RISING_EDGE_ENABLE) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_FALLING_EDGE_ENABLE) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_CHANGE_FLAGS) begin
            addr_ok = 1'b1;
        end else if (paddr_i == gpec_pkg::OFF_PORT_CONFIG) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_comb begin
        pin_read = dig_in;
        if (mclr_sel_q) begin
            pin_read[gpec_pkg::IN_ONLY_PIN] = 1'b0;
        end
    end

    // read data is captured in the setup cycle and presented in the access cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end else if (setup) begin
            err_q <= ~addr_ok;
            if (paddr_i == gpec_pkg::OFF_PIN_DATA) begin
                rdata_q <= word6(pin_read);
            end else if (paddr_i == gpec_pkg::OFF_OUTPUT_LATCH) begin
                rdata_q <= word6(latch_q);
            end else if (paddr_i == gpec_pkg::OFF_PIN_DIRECTION) begin
                rdata_q <= word6(dir_q);
            end else if (paddr_i == gpec_pkg::OFF_ANALOG_SELECT) begin
                rdata_q <= word6(ansel_q);
            end else if (paddr_i == gpec_pkg::OFF_RISING_EDGE_ENABLE) begin
                rdata_q <= word6(rise_en_q);
            end else if (paddr_i == gpec_pkg::OFF_FALLING_EDGE_ENABLE) begin
                rdata_q <= word6(fall_en_q);
            end else if (paddr_i == gpec_pkg::OFF_CHANGE_FLAGS) begin
                rdata_q <= word6(flags_q);
            end else if (paddr_i == gpec_pkg::OFF_PORT_CONFIG) begin
                rdata_q <= {30'h0, change_pending_o, mclr_sel_q};
            end else begin
                rdata_q <= 32'h0;
            end
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & err_q;
    assign prdata_o = rdata_q;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic wr_lane0;
    assign wr_lane0 = wr_acc & pstrb_i[0];

    // read-modify-write
    // an unstrobed data write still copies the sampled pins into the latch
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            latch_q <= gpec_pkg::RST_LATCH;
        end else if (wr_acc && paddr_i == gpec_pkg::OFF_PIN_DATA) begin
            latch_q <= pstrb_i[0] ? wbyte : pin_read;
        end else if (wr_lane0 && paddr_i == gpec_pkg::OFF_OUTPUT_LATCH) begin
            latch_q <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dir_q <= gpec_pkg::RST_DIRECTION;
        end else if (wr_lane0 && paddr_i == gpec_pkg::OFF_PIN_DIRECTION) begin
            dir_q <= wbyte;
            dir_q[gpec_pkg::IN_ONLY_PIN] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ansel_q <= gpec_pkg::RST_ANALOG;
        end else if (wr_lane0 && paddr_i == gpec_pkg::OFF_ANALOG_SELECT) begin
            ansel_q <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rise_en_q <= gpec_pkg::RST_EDGE_EN;
            fall_en_q <= gpec_pkg::RST_EDGE_EN;
        end else if (wr_lane0) begin
            if (paddr_i == gpec_pkg::OFF_RISING_EDGE_ENABLE) begin
                rise_en_q <= wbyte;
            end
            if (paddr_i == gpec_pkg::OFF_FALLING_EDGE_ENABLE) begin
                fall_en_q <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mclr_sel_q <= gpec_pkg::RST_MCLR;
        end else if (wr_lane0 && paddr_i == gpec_pkg::OFF_PORT_CONFIG) begin
            mclr_sel_q <= pwdata_i[gpec_pkg::CFG_MCLR_BIT];
        end
    end

    // ------------------------------------------------------------
    // edge detection and change flags
    // ------------------------------------------------------------
    logic [N-1:0] rise_ev;
    logic [N-1:0] fall_ev;
    logic [N-1:0] set_ev;
    logic [N-1:0] dig_ok;
    logic [N-1:0] flags_d;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dig_prev_q <= '0;
            ansel_prev_q <= gpec_pkg::RST_ANALOG;
        end else begin
            dig_prev_q <= dig_in;
            ansel_prev_q <= ansel_q;
        end
    end

    // analog never flags
    // leaving analog mode must not look like an edge, so both cycles must be digital
    assign dig_ok = ~ansel_q & ~ansel_prev_q;
    assign rise_ev = rise_en_q & dig_in & ~dig_prev_q & dig_ok;
    assign fall_ev = fall_en_q & ~dig_in & dig_prev_q & dig_ok;
    assign set_ev = rise_ev | fall_ev;

    // hardware set
    // a hardware set in the cycle of a clearing write wins
    always_comb begin
        flags_d = flags_q;
        if (wr_lane0 && paddr_i == gpec_pkg::OFF_CHANGE_FLAGS) begin
            flags_d = wbyte;
        end
        flags_d = flags_d | set_ev;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flags_q <= gpec_pkg::RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign change_pending_o = |flags_q;

    // ------------------------------------------------------------
    // output priority mux and drivers
    // ------------------------------------------------------------
    logic [N-1:0] pin_val;

    always_comb begin
        pin_val = latch_q;
        if (periph_i.amp_en) begin
            pin_val[gpec_pkg::PIN_AMP] = periph_i.amp;
        end
        if (periph_i.comp_one_en) begin
            pin_val[gpec_pkg::PIN_FOUR] = periph_i.comp_one;
        end else if (periph_i.cmp_two_en) begin
            pin_val[gpec_pkg::PIN_FOUR] = periph_i.cmp_two;
        end
        if (periph_i.comp_zero_en) begin
            pin_val[gpec_pkg::PIN_FIVE] = periph_i.comp_zero;
        end else if (periph_i.ccp_en) begin
            pin_val[gpec_pkg::PIN_FIVE] = periph_i.ccp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pad_o <= '0;
            pad_oe_o <= '0;
        end else begin
            pad_o <= pin_val;
            pad_oe_o <= ~dir_q;
            pad_o[gpec_pkg::IN_ONLY_PIN] <= 1'b0;
            pad_oe_o[gpec_pkg::IN_ONLY_PIN] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // analog input connections
    // ------------------------------------------------------------
    logic [N-1:0] ana_conn_d;

    // analog function select
    // connection follows the peripheral alone; software must also set direction
    // gathered in one variable so every enabled function counts, not only the last
    always_comb begin
        ana_conn_d = '0;
        for (int f = 0; f < NUM_AFN; f++) begin
            if (afn_i[f].en) begin
                ana_conn_d = ana_conn_d | pin_decode(afn_i[f].sel);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ana_conn_o <= '0;
        end else begin
            ana_conn_o <= ana_conn_d;
        end
    end

endmodule

// file: dv/gpec_port_checker.sv
// concurrent checks on the six-pin port, seen from its ports only
// assumes a single clock domain and the synchronous active-low reset
`timescale 1ns/10ps

module gpec_port_checker #(
    parameter int NUM_AFN = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins and peripherals
    input wire logic [gpec_pkg::NUM_PINS-1:0] pad_i,
    input wire logic [gpec_pkg::NUM_PINS-1:0] pad_o,
    input wire logic [gpec_pkg::NUM_PINS-1:0] pad_oe_o,
    input wire gpec_pkg::gpec_periph_t periph_i,
    input wire gpec_pkg::gpec_afn_t [NUM_AFN-1:0] afn_i,
    input wire logic [gpec_pkg::NUM_PINS-1:0] ana_conn_o,
    input wire logic [gpec_pkg::NUM_PINS-1:0] dig_in_o,
    input wire logic change_pending_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // expected analog connections, one cycle behind the selectors
    logic [5:0] conn_d;
    logic [5:0] conn_q;
    always_comb begin
        conn_d = 6'h00;
        for (int k = 0; k < NUM_AFN; k++) begin
            if (afn_i[k].en && afn_i[k].sel < 3'h6) begin
                conn_d[afn_i[k].sel] = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        conn_q <= conn_d;
    end

    a_pin3_undriven: assert property (pad_oe_o[3] == 1'b0 && pad_o[3] == 1'b0)
        else $error("input-only pin driven");
    a_quiet_after_reset: assert property ($rose(rst_b_i) |->
        pad_oe_o == 6'h00 && change_pending_o == 1'b0 && ana_conn_o == 6'h00)
        else $error("outputs not quiet after reset");
    a_upper_read_zero: assert property (psel_i && penable_i && !pwrite_i |->
        prdata_o[31:6] == 26'h0) else $error("upper read bits set");
    a_oe_needs_write: assert property ($past(rst_b_i) && $changed(pad_oe_o) |->
        $past(psel_i && penable_i && pwrite_i, 2)) else $error("driver enable moved alone");
    a_pin4_first_owner: assert property ($past(rst_b_i) && $past(periph_i.comp_one_en) |->
        pad_o[4] == $past(periph_i.comp_one)) else $error("pin four not first owner");
    a_pin4_second_owner: assert property ($past(rst_b_i) &&
        $past(!periph_i.comp_one_en && periph_i.cmp_two_en) |->
        pad_o[4] == $past(periph_i.cmp_two)) else $error("pin four not second owner");
    a_pin5_first_owner: assert property ($past(rst_b_i) && $past(periph_i.comp_zero_en) |->
        pad_o[5] == $past(periph_i.comp_zero)) else $error("pin five not first owner");
    a_pin2_amp_owner: assert property ($past(rst_b_i) && $past(periph_i.amp_en) |->
        pad_o[2] == $past(periph_i.amp)) else $error("pin two not amplifier");
    a_conn_follows_sel: assert property ($past(rst_b_i) |-> ana_conn_o == conn_q)
        else $error("analog connection wrong");
    a_level_rise_cause: assert property ($past(rst_b_i) && $rose(dig_in_o[0]) |->
        $past(pad_i[0], 3)) else $error("digital level rose without pin");
    a_pend_rise_cause: assert property ($past(rst_b_i) && $rose(change_pending_o) |->
        $past(pad_i, 5) != $past(pad_i, 6) || $past(psel_i && penable_i && pwrite_i))
        else $error("pending rose without cause");

    c_pend_seen: cover property ($rose(change_pending_o));
    c_err_seen: cover property (psel_i && penable_i && pslverr_o);
    c_both_owners: cover property (periph_i.comp_one_en && periph_i.cmp_two_en);
endmodule

bind gpec_port gpec_port_checker #(.NUM_AFN(NUM_AFN)) chk_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .periph_i(periph_i), .afn_i(afn_i),
    .ana_conn_o(ana_conn_o), .dig_in_o(dig_in_o), .change_pending_o(change_pending_o));

// file: dv/gpec_pins_model.sv
// outside circuitry on the six pins
// assumes the port's drivers win; undriven, unheld pins wander every cycle
`timescale 1ns/10ps

module gpec_pins_model (
    // clock
    input wire logic clk_i,
    // from the port
    input wire logic [5:0] pin_out_i,
    input wire logic [5:0] pin_oe_i,
    // outside sources
    input wire logic [5:0] ext_en_i,
    input wire logic [5:0] ext_lvl_i,
    // to the port
    output logic [5:0] pin_lvl_o
);
    // no pull on these pins, so a floating level must not look stable
    logic [5:0] float_q = 6'h15;
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            pin_lvl_o[k] = pin_oe_i[k] ? pin_out_i[k] : (ext_en_i[k] ? ext_lvl_i[k] : float_q[k]);
        end
    end
endmodule

// file: dv/gpec_port_edge_change_irq_tb_top.sv
// self-checking bench for the six-pin port over apb
// assumes the pin model on the pads and the checker bound to the port
`timescale 1ns/10ps

module gpec_port_edge_change_irq_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, serr, pend;
    logic [5:0] pad_i, pad_o, pad_oe, ana_conn, dig_in;
    logic [5:0] ext_en = 6'h3f, ext_lvl = 6'h3f;
    gpec_pkg::gpec_periph_t periph = '0;
    gpec_pkg::gpec_afn_t [3:0] afn = '0;
    int failures = 0, tests_run = 0, cyc = 0;
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h3f, 32'h3f, 32'h0, 32'h0, 32'h0, 32'h0};

    always #10 clk = ~clk;

    gpec_port dut_u (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pad_i(pad_i),
        .pad_o(pad_o), .pad_oe_o(pad_oe), .periph_i(periph), .afn_i(afn),
        .ana_conn_o(ana_conn), .dig_in_o(dig_in), .change_pending_o(pend));
    gpec_pins_model pins_u (.clk_i(clk), .pin_out_i(pad_o), .pin_oe_i(pad_oe),
        .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pin_lvl_o(pad_i));

    task tally_and_finish();
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer; entered just after a rising edge, leaves one idle cycle
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        wt(12);
        rst_b <= 1'b1;
        wt(1);
        for (int i = 0; i < 8; i++) rchk(ra[i], rv[i]);
        wr(8'h20, 32'hff);
        rchk(8'h20, 32'h0);
        chk(serr, 1'b1);
        // driver control, analog still selected everywhere
        wr(gpec_pkg::OFF_PIN_DIRECTION, 32'h0);
        rchk(gpec_pkg::OFF_PIN_DIRECTION, 32'h08);
        wr(gpec_pkg::OFF_OUTPUT_LATCH, 32'h15);
        wt(1);
        chk(pad_oe, 6'h37);
        chk(pad_o, 6'h15);
        rchk(gpec_pkg::OFF_PIN_DATA, 32'h0);
        wr(gpec_pkg::OFF_ANALOG_SELECT, 32'h0);
        wt(6);
        rchk(gpec_pkg::OFF_PIN_DATA, 32'h1d);
        wr(gpec_pkg::OFF_PORT_CONFIG, 32'h1);
        rchk(gpec_pkg::OFF_PIN_DATA, 32'h15);
        wr(gpec_pkg::OFF_PORT_CONFIG, 32'h0);
        wr(gpec_pkg::OFF_PIN_DATA, 32'h22);
        rchk(gpec_pkg::OFF_OUTPUT_LATCH, 32'h22);
        chk(pad_o, 6'h22);
        wr(gpec_pkg::OFF_PIN_DIRECTION, 32'h3f);
        wt(1);
        chk(pad_oe, 6'h00);
        ext_lvl <= 6'h07;
        wt(6);
        pstrb <= 4'h0;
        wr(gpec_pkg::OFF_PIN_DATA, 32'h38);
        pstrb <= 4'hf;
        rchk(gpec_pkg::OFF_OUTPUT_LATCH, 32'h07);
        // edge detection; pin five left floating from here on
        ext_en <= 6'h1f;
        ext_lvl <= 6'h00;
        wt(6);
        wr(gpec_pkg::OFF_CHANGE_FLAGS, 32'h0);
        wr(gpec_pkg::OFF_RISING_EDGE_ENABLE, 32'hff);
        rchk(gpec_pkg::OFF_RISING_EDGE_ENABLE, 32'h3f);
        wr(gpec_pkg::OFF_RISING_EDGE_ENABLE, 32'h01);
        wr(gpec_pkg::OFF_FALLING_EDGE_ENABLE, 32'h02);
        ext_lvl <= 6'h03;
        wt(6);
        rchk(gpec_pkg::OFF_CHANGE_FLAGS, 32'h01);
        chk(pend, 1'b1);
        ext_lvl <= 6'h00;
        wt(6);
        rchk(gpec_pkg::OFF_CHANGE_FLAGS, 32'h03);
        wr(gpec_pkg::OFF_CHANGE_FLAGS, 32'h0);
        rchk(gpec_pkg::OFF_CHANGE_FLAGS, 32'h0);
        chk(pend, 1'b0);
        // analog pin keeps quiet whatever its enables hold
        wr(gpec_pkg::OFF_ANALOG_SELECT, 32'h04); // direction already input
        wr(gpec_pkg::OFF_RISING_EDGE_ENABLE, 32'h04);
        wr(gpec_pkg::OFF_FALLING_EDGE_ENABLE, 32'h04);
        ext_lvl <= 6'h04;
        wt(6);
        chk(dig_in[2:0], 3'h0);
        ext_lvl <= 6'h00;
        wt(6);
        rchk(gpec_pkg::OFF_CHANGE_FLAGS, 32'h0);
        // output ownership, pin two still analog
        wr(gpec_pkg::OFF_OUTPUT_LATCH, 32'h0);
        wr(gpec_pkg::OFF_PIN_DIRECTION, 32'h0);
        periph <= gpec_pkg::gpec_periph_t'(10'h3af);
        wt(2);
        chk(pad_o, 6'h14);
        periph <= gpec_pkg::gpec_periph_t'(10'h12f);
        wt(2);
        chk(pad_o, 6'h24);
        periph <= gpec_pkg::gpec_periph_t'(10'h000);
        wr(gpec_pkg::OFF_PIN_DIRECTION, 32'h3f);
        chk(pad_o, 6'h00);
        afn <= 16'h00fa;
        wt(2);
        chk(ana_conn, 6'h04);
        tally_and_finish();
    end
endmodule
